// >>> rtl/acrp_addr_if.sv
// Purpose: carries latched address from latch to register file
// Assumes: single clock
// Notes:   none
`default_nettype none
interface acrp_addr_if;
    logic [7:0] addr;
    logic       test_sel;
    modport src (output addr, output test_sel);
    modport dst (input addr, input test_sel);
endinterface : acrp_addr_if
`default_nettype wire

// >>> rtl/acrp_addr_latch.sv
// Purpose: transparent address latch controlled by latch enable
// Assumes: inputs synchronous to ref_clk
// Notes:   latch modelled as a flop with bypass
`default_nettype none
module acrp_addr_latch (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // host pins
    input  wire logic [7:0] register_select_lines,
    input  wire logic       address_latch_enable,
    // latched address
    acrp_addr_if.src        out
);
    logic [7:0] held_r;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            held_r <= acrp_pkg::RST_VALUE;
        end else if (address_latch_enable) begin
            held_r <= register_select_lines;
        end
    end

    // transparent while enable high, hold otherwise
    assign out.addr     = address_latch_enable ? register_select_lines : held_r;
    assign out.test_sel = out.addr[acrp_pkg::TEST_BIT];

    chk_latch_holds : assert property (@(posedge ref_clk) disable iff (!rstn)
        !address_latch_enable && !$past(address_latch_enable) |-> $stable(out.addr))
        else $error("address changed while latch closed");
endmodule : acrp_addr_latch
`default_nettype wire

// >>> rtl/acrp_host_port.sv
// Purpose: asynchronous 8-bit host register port of the device
// Assumes: strobes sampled on ref_clk; host keeps its own timing
// Notes:   data bus split into in, out and enable (enable low = drive)
// Functional notes
// - drive data while read and select low
// - store data on write strobe rise
// - data bus is bidirectional eight bits
// - decode address to select register
// - address latch transparent when enable high
// - reset acts asynchronously, active low
// - irq low while unmasked source active
`default_nettype none
module acrp_host_port (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // host strobes
    input  wire logic       chip_select_n,
    input  wire logic       read_strobe_n,
    input  wire logic       write_strobe_n,
    // address
    input  wire logic [7:0] register_select_lines,
    input  wire logic       address_latch_enable,
    // data bus
    input  wire logic [7:0] host_bus_in,
    output logic      [7:0] host_bus_out,
    output logic            host_bus_oe_n,
    // device side
    input  wire logic [7:0] event_in,
    output logic      [7:0] control_out,
    output logic            test_access,
    // interrupt, open drain
    output logic            irq_n_out,
    output logic            irq_n_oe_n
);
    acrp_addr_if a_if ();
    logic [7:0] scratch_r;
    logic [7:0] control_r;
    logic [7:0] stat_r;
    logic [7:0] mask_r;
    logic [7:0] test_r;
    logic [7:0] rdata;
    logic [7:0] clr_mask;
    logic       wr_d_r;
    logic       wr_rise;
    logic       sel_wr_r;
    logic       irq_act;

    acrp_addr_latch u_latch (
        .ref_clk               (ref_clk),
        .rstn                  (rstn),
        .register_select_lines (register_select_lines),
        .address_latch_enable  (address_latch_enable),
        .out                   (a_if)
    );

    function automatic logic hit(input logic [7:0] a, input logic [6:0] ofs);
        hit = (a[6:0] == ofs);
    endfunction : hit

    // edge of write strobe; select must have been low with it
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wr_d_r   <= 1'b1;
            sel_wr_r <= 1'b0;
        end else begin
            wr_d_r   <= write_strobe_n;
            sel_wr_r <= !chip_select_n && !write_strobe_n;
        end
    end
    assign wr_rise = write_strobe_n && !wr_d_r && sel_wr_r;

    // normal-space writable registers
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            scratch_r <= acrp_pkg::RST_VALUE;
            control_r <= acrp_pkg::RST_VALUE;
            mask_r    <= acrp_pkg::RST_VALUE;
        end else if (wr_rise && !a_if.test_sel) begin
            if (hit(a_if.addr, acrp_pkg::OFS_SCRATCH)) scratch_r <= host_bus_in;
            if (hit(a_if.addr, acrp_pkg::OFS_CONTROL)) control_r <= host_bus_in;
            if (hit(a_if.addr, acrp_pkg::OFS_IRQ_MASK)) mask_r <= host_bus_in;
        end
    end

    // test-space register kept apart so test writes never disturb normal state
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            test_r <= acrp_pkg::RST_VALUE;
        end else if (wr_rise && a_if.test_sel && hit(a_if.addr, acrp_pkg::OFS_SCRATCH)) begin
            test_r <= host_bus_in;
        end
    end

    // sticky status, write one to clear; a new event wins over the clear
    assign clr_mask = (wr_rise && !a_if.test_sel && hit(a_if.addr, acrp_pkg::OFS_IRQ_STAT))
                      ? host_bus_in : acrp_pkg::READ_ZERO;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stat_r <= acrp_pkg::RST_VALUE;
        end else begin
            stat_r <= (stat_r & ~clr_mask) | event_in;
        end
    end

    assign irq_act = |(stat_r & mask_r);

    // read mux
    always_comb begin
        rdata = acrp_pkg::READ_ZERO;
        if (a_if.test_sel) begin
            if (hit(a_if.addr, acrp_pkg::OFS_SCRATCH)) rdata = test_r;
        end else begin
            unique case (a_if.addr[6:0])
                acrp_pkg::OFS_SCRATCH:  rdata = scratch_r;
                acrp_pkg::OFS_CONTROL:  rdata = control_r;
                acrp_pkg::OFS_IRQ_STAT: rdata = stat_r;
                acrp_pkg::OFS_IRQ_MASK: rdata = mask_r;
                acrp_pkg::OFS_ID:       rdata = acrp_pkg::ID_VALUE;
                default:                rdata = acrp_pkg::READ_ZERO;
            endcase
        end
    end

    // read data registered; one cycle latency after strobe falls
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            host_bus_out  <= acrp_pkg::READ_ZERO;
            host_bus_oe_n <= 1'b1;
        end else begin
            host_bus_out  <= rdata;
            host_bus_oe_n <= read_strobe_n || chip_select_n;
        end
    end

    assign control_out = control_r;
    assign test_access = a_if.test_sel;
    assign irq_n_out   = 1'b0;
    assign irq_n_oe_n  = !irq_act;

    chk_bus_release : assert property (@(posedge ref_clk) disable iff (!rstn)
        (read_strobe_n || chip_select_n) |=> host_bus_oe_n)
        else $error("bus driven outside read");
    chk_bus_drive : assert property (@(posedge ref_clk) disable iff (!rstn)
        (!read_strobe_n && !chip_select_n) |=> !host_bus_oe_n)
        else $error("bus not driven during read");
    chk_read_data : assert property (@(posedge ref_clk) disable iff (!rstn)
        (!read_strobe_n && !chip_select_n && !a_if.test_sel && a_if.addr[6:0] == acrp_pkg::OFS_ID)
        |=> host_bus_out == acrp_pkg::ID_VALUE)
        else $error("wrong read data");
    chk_write_store : assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr_rise && !a_if.test_sel && a_if.addr[6:0] == acrp_pkg::OFS_CONTROL)
        |=> control_r == $past(host_bus_in))
        else $error("write not stored");
    chk_no_write : assert property (@(posedge ref_clk) disable iff (!rstn)
        !wr_rise |=> $stable(control_r))
        else $error("control changed without write");
    chk_test_space : assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr_rise && a_if.test_sel) |=> $stable(scratch_r) && $stable(mask_r))
        else $error("test write hit normal space");
    chk_irq_level : assert property (@(posedge ref_clk) disable iff (!rstn)
        irq_n_oe_n == !(|(stat_r & mask_r)))
        else $error("irq not tracking sources");
    chk_event_sticky : assert property (@(posedge ref_clk) disable iff (!rstn)
        (event_in != acrp_pkg::READ_ZERO) |=> ((stat_r & $past(event_in)) == $past(event_in)))
        else $error("event lost");
    chk_reset_state : assert property (@(posedge ref_clk)
        !rstn |-> host_bus_oe_n && control_r == acrp_pkg::RST_VALUE)
        else $error("reset not applied");
    chk_latch_pass : assert property (@(posedge ref_clk) disable iff (!rstn)
        address_latch_enable |-> a_if.addr == register_select_lines)
        else $error("address latch not transparent");
    chk_scratch_store : assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr_rise && !a_if.test_sel && a_if.addr[6:0] == acrp_pkg::OFS_SCRATCH)
        |=> scratch_r == $past(host_bus_in))
        else $error("scratch write not stored");
    chk_mask_store : assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr_rise && !a_if.test_sel && a_if.addr[6:0] == acrp_pkg::OFS_IRQ_MASK)
        |=> mask_r == $past(host_bus_in))
        else $error("mask write not stored");
    chk_test_store : assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr_rise && a_if.test_sel && a_if.addr[6:0] == acrp_pkg::OFS_SCRATCH)
        |=> test_r == $past(host_bus_in))
        else $error("test scratch write not stored");
    chk_stat_clear : assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr_rise && !a_if.test_sel && a_if.addr[6:0] == acrp_pkg::OFS_IRQ_STAT)
        |=> (stat_r & $past(host_bus_in) & ~$past(event_in)) == acrp_pkg::READ_ZERO)
        else $error("status bit not cleared");
    chk_select_gate : assert property (@(posedge ref_clk) disable iff (!rstn)
        (write_strobe_n && !wr_d_r && !sel_wr_r)
        |=> $stable(scratch_r) && $stable(control_r) && $stable(mask_r))
        else $error("write stored without chip select");
    // read data is registered, so it must match the register one cycle earlier
    chk_read_scratch : assert property (@(posedge ref_clk) disable iff (!rstn)
        (!read_strobe_n && !chip_select_n && !a_if.test_sel && a_if.addr[6:0] == acrp_pkg::OFS_SCRATCH)
        |=> host_bus_out == $past(scratch_r))
        else $error("scratch read data wrong");
    chk_read_control : assert property (@(posedge ref_clk) disable iff (!rstn)
        (!read_strobe_n && !chip_select_n && !a_if.test_sel && a_if.addr[6:0] == acrp_pkg::OFS_CONTROL)
        |=> host_bus_out == $past(control_r))
        else $error("control read data wrong");
    chk_read_stat : assert property (@(posedge ref_clk) disable iff (!rstn)
        (!read_strobe_n && !chip_select_n && !a_if.test_sel && a_if.addr[6:0] == acrp_pkg::OFS_IRQ_STAT)
        |=> host_bus_out == $past(stat_r))
        else $error("status read data wrong");
    chk_read_mask : assert property (@(posedge ref_clk) disable iff (!rstn)
        (!read_strobe_n && !chip_select_n && !a_if.test_sel && a_if.addr[6:0] == acrp_pkg::OFS_IRQ_MASK)
        |=> host_bus_out == $past(mask_r))
        else $error("mask read data wrong");
    chk_read_test : assert property (@(posedge ref_clk) disable iff (!rstn)
        (!read_strobe_n && !chip_select_n && a_if.test_sel && a_if.addr[6:0] == acrp_pkg::OFS_SCRATCH)
        |=> host_bus_out == $past(test_r))
        else $error("test scratch read data wrong");
    chk_read_unmapped : assert property (@(posedge ref_clk) disable iff (!rstn)
        (!read_strobe_n && !chip_select_n && a_if.test_sel && a_if.addr[6:0] != acrp_pkg::OFS_SCRATCH)
        |=> host_bus_out == acrp_pkg::READ_ZERO)
        else $error("unmapped test read not zero");
    chk_irq_assert : assert property (@(posedge ref_clk) disable iff (!rstn)
        ((stat_r & mask_r) != acrp_pkg::READ_ZERO) |-> !irq_n_oe_n && irq_n_out == 1'b0)
        else $error("irq pin not pulled low");
endmodule : acrp_host_port
`default_nettype wire

// >>> rtl/acrp_pkg.sv
// Purpose: shared constants for the host register port
// Assumes: 8-bit address and data, synchronous sampled strobes
// Notes:   register offsets are local choices of this block
`default_nettype none
package acrp_pkg;
    localparam int            ADDR_W       = 8;
    localparam int            DATA_W       = 8;
    localparam int            TEST_BIT     = 7;
    localparam int            NUM_REGS     = 8;
    localparam logic [6:0]    OFS_SCRATCH  = 7'h00;
    localparam logic [6:0]    OFS_CONTROL  = 7'h01;
    localparam logic [6:0]    OFS_IRQ_STAT = 7'h02;
    localparam logic [6:0]    OFS_IRQ_MASK = 7'h03;
    localparam logic [6:0]    OFS_ID       = 7'h04;
    localparam logic [7:0]    RST_VALUE    = 8'h00;
    localparam logic [7:0]    ID_VALUE     = 8'h5a; // arbitrary value
    localparam logic [7:0]    READ_ZERO    = 8'h00;
endpackage : acrp_pkg
`default_nettype wire

// >>> tb/acrp_host_model.sv
// Purpose: host processor model for the strobe-timed register port
// Assumes: host changes pins on falling edges of ref_clk
// Notes:   released data shows the inverse of the last byte
`default_nettype none
module acrp_host_model (
    // clock
    input  wire logic       ref_clk,
    // strobes and address
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic      [7:0] addr,
    output logic            ale,
    // data bus
    output logic      [7:0] drv,
    input  wire logic [7:0] bus
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 8'h00;
        ale  = 1'b1;
        drv  = 8'h00;
    end
    // sel high makes a refused write; hold moves the lines while latched
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic sel, input logic hold);
        @(negedge ref_clk);
        addr = a;
        drv  = v;
        @(negedge ref_clk);
        cs_n = sel;
        wr_n = 1'b0;
        if (hold) begin
            ale  = 1'b0;
            addr = ~a;
        end
        repeat (2) @(negedge ref_clk);
        wr_n = 1'b1;
        @(negedge ref_clk);
        cs_n = 1'b1;
        drv  = ~v;
        ale  = 1'b1;
        addr = a;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge ref_clk);
        addr = a;
        @(negedge ref_clk);
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        v    = bus;
        rd_n = 1'b1;
        cs_n = 1'b1;
    endtask : rd
endmodule : acrp_host_model
`default_nettype wire

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the host register port
// Assumes: design samples strobes on ref_clk
// Notes:   expectations come from a byte map kept in the bench
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b1;
    logic        tie_cs = 1'b0;
    logic        cs_pin;
    logic        cs_n, rd_n, wr_n, ale, oe_n, irq_oe_n, irq_o, tacc, x;
    logic [7:0]  addr, drv, bus, dout, ctl, d, a8;
    logic [7:0]  ev = 8'h00;
    logic [31:0] rng = 32'h6f18;
    logic [7:0]  aset[8] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h7f, 8'h80, 8'h81};
    int          num_errors = 0;
    int          check_count = 0;
    int          mdl[int];
    always #5 ref_clk = ~ref_clk;
    assign bus = !oe_n ? dout : drv;
    // strobe-only systems hold select at the inverse of reset
    assign cs_pin = tie_cs ? !rstn : cs_n;
    acrp_host_model host (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .ale(ale),
        .drv(drv), .bus(bus));
    acrp_host_port dut (.ref_clk(ref_clk), .rstn(rstn), .chip_select_n(cs_pin), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .register_select_lines(addr), .address_latch_enable(ale), .host_bus_in(bus),
        .host_bus_out(dout), .host_bus_oe_n(oe_n), .event_in(ev), .control_out(ctl), .test_access(tacc),
        .irq_n_out(irq_o), .irq_n_oe_n(irq_oe_n));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        if (a == {1'b0, acrp_pkg::OFS_ID}) return acrp_pkg::ID_VALUE;
        return mdl.exists(a) ? 8'(mdl[a]) : acrp_pkg::READ_ZERO;
    endfunction : exp_rd
    task automatic chk(input logic [7:0] got, input logic [7:0] e);
        check_count++;
        if (got !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask : chk
    task automatic w(input logic [7:0] a, input logic [7:0] v);
        host.wr(a, v, 1'b0, 1'b0);
        if (a inside {8'h00, 8'h01, 8'h03, 8'h80}) mdl[a] = v;
    endtask : w
    task automatic r(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, d);
        chk(d, e);
        chk({7'h00, oe_n}, 8'h00);
        repeat (2) @(negedge ref_clk);
        chk({7'h00, oe_n}, 8'h01);
    endtask : r
    task automatic pulse(input logic [7:0] v);
        @(negedge ref_clk);
        ev = v;
        @(negedge ref_clk);
        ev = 8'h00;
        repeat (2) @(negedge ref_clk);
    endtask : pulse
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        #100000;
        num_errors++;
        finish_test();
    end
    initial begin
        // drop after time zero so the asynchronous reset sees a real edge
        #1 rstn = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk({ctl[7:1], irq_oe_n}, 8'h01);
        chk({7'h00, oe_n}, 8'h01);
        rstn = 1'b1;
        for (int k = 0; k < 24; k++) begin
            a8  = aset[k % 8];
            rng = xs(rng);
            w(a8, rng[7:0]);
            r(a8, exp_rd(a8));
            chk({7'h00, tacc}, {7'h00, a8[7]});
        end
        chk(ctl, exp_rd(8'h01));
        $display("test access done");
        host.wr(8'h01, ~ctl, 1'b1, 1'b0);
        chk(ctl, exp_rd(8'h01));
        rng = xs(rng);
        host.wr(8'h00, rng[7:0], 1'b0, 1'b1);
        mdl[0] = rng[7:0];
        r(8'h00, rng[7:0]);
        $display("test select and latch done");
        w(8'h03, 8'hff);
        pulse(8'h04);
        x = irq_oe_n;
        r(8'h02, 8'h04);
        w(8'h02, 8'h04);
        chk({7'h00, irq_oe_n}, 8'h01);
        r(8'h02, 8'h00);
        w(8'h03, 8'h00);
        pulse(8'h04);
        chk({6'h00, x ^ irq_oe_n, irq_o}, 8'h02);
        w(8'h02, 8'hff);
        $display("test interrupt done");
        @(negedge ref_clk);
        tie_cs = 1'b1;
        rng = xs(rng);
        w(8'h01, rng[7:0]);
        r(8'h01, rng[7:0]);
        chk(ctl, rng[7:0]);
        @(negedge ref_clk);
        tie_cs = 1'b0;
        $display("test strobe-only select done");
        w(8'h01, 8'ha5);
        @(negedge ref_clk);
        rstn = 1'b0;
        #1 chk(ctl, acrp_pkg::RST_VALUE);
        @(negedge ref_clk);
        rstn = 1'b1;
        mdl.delete();
        r(8'h00, acrp_pkg::RST_VALUE);
        $display("test reset done");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
